// ### tb/serial_peer.sv
// partner model: external synchronous serial device
// assumes: the bench resolves all pin levels and feeds them in
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
   // pins
   input wire logic sclk_i,
   input wire logic din_i,
   output logic dout_o,
   output logic sclk_o,
   // set-up
   input wire logic tx_edge_i,
   output logic [7:0] got_o
);
   logic [7:0] send;
   logic rel;
   int idx;
   initial begin
      dout_o = 1'b1;
      sclk_o = 1'b1;
      got_o = 8'h00;
      send = 8'h00;
      rel = 1'b0;
      idx = -1;
   end
   // launch so the device samples on its own sampling edge
   always @(sclk_i) begin
      if (sclk_i === (tx_edge_i ^ rel) && idx >= 0) begin
         dout_o = send[idx];
         idx = idx - 1;
      end
      if (sclk_i === ~tx_edge_i)
         got_o = {got_o[6:0], din_i};
   end
   // idle level first, so that change is not taken as a bit
   task automatic arm(input logic [7:0] b, input logic r, input logic idle);
      sclk_o = idle;
      #1;
      rel = r;
      send = b;
      got_o = 8'h00;
      dout_o = b[7];
      idx = r ? 6 : 7;
   endtask
   // slave clock, stands still outside the frame
   task automatic run_clock(input int half);
      for (int k = 0; k < 16; k++) begin
         #(half);
         sclk_o = ~sclk_o;
      end
   endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench: serial channel against the peer model, random and corner cases
// assumes: design in verilog/, peer model in tb/serial_peer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic mclk_i, reset_n, wr, rd, tick, p_tx, two, p_clk, ce;
   logic [1:0] tcnt;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, r, nedge, gmin, gmax, gap, got;
   logic sclk_o, sclk_oe_n, dout_o, dout_oe_n, free, busy, irq;
   logic last_c, last_d, chk_edge, txl;
   int err_count, tests_run, cyc;
   wire logic p_d;
   wire logic sclk_w = sclk_oe_n ? p_clk : sclk_o;
   wire logic dout_w = dout_oe_n ? (two ? p_d : 1'b1) : dout_o;
   wire logic din_w = two ? ~p_d : p_d;

   sync_serial_edge_clock_pins i_sync_serial_edge_clock_pins (
      .mclk_i(mclk_i), .reset_n_i(reset_n), .ce_i(ce),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .timer3_tick_i(tick),
      .shift_clk_pin_i(sclk_w), .shift_clk_pin_o(sclk_o),
      .shift_clk_pin_oe_n_o(sclk_oe_n), .data_out_pin_i(dout_w),
      .data_out_pin_o(dout_o), .data_out_pin_oe_n_o(dout_oe_n),
      .data_in_pin_i(din_w), .data_in_pin_free_o(free),
      .transfer_active_flag_o(busy), .xfer_done_irq_o(irq));
   serial_peer i_peer (
      .sclk_i(sclk_w), .din_i(dout_w), .dout_o(p_d), .sclk_o(p_clk),
      .tx_edge_i(p_tx), .got_o(got));

   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   // timer pulse every 3 cycles
   always @(posedge mclk_i) begin
      tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
      tick <= (tcnt == 2'h2);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] q);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 q = rdata;
   endtask
   function automatic logic [7:0] half(input logic [1:0] s, input logic d);
      logic [7:0] h;
      h = (s == 2'h0) ? 8'h01 : (s == 2'h1) ? 8'h02 :
          (s == 2'h2) ? 8'h08 : 8'h03;
      return d ? {h[4:0], 3'b000} : h;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // clock edge count, half-period spread and data-change edge
   always @(negedge mclk_i) begin
      gap = gap + 8'h01;
      if (sclk_w !== last_c) begin
         if (nedge != 8'h00 && gap < gmin) gmin = gap;
         if (nedge != 8'h00 && gap > gmax) gmax = gap;
         nedge = nedge + 8'h01;
         gap = 8'h00;
      end
      if (chk_edge && dout_w !== last_d)
         chk1(sclk_w, txl);
      last_c = sclk_w;
      last_d = dout_w;
   end

   task automatic frame(input logic m, input logic [1:0] src,
      input logic dv, input logic tx, input logic rel,
      input logic tw, input logic dir);
      logic [7:0] pb, db, hf;
      logic cod, ood;
      pb = 8'($urandom);
      db = 8'($urandom);
      cod = 1'($urandom);
      ood = 1'($urandom);
      hf = half(src, dv);
      p_tx = tx;
      // peer stays off the shared pin while we transmit on it
      two = tw & ~dir;
      wr_reg(3'h4, 8'($urandom));
      wr_reg(3'h0, {1'b0, tw, m, dv, src, rel, tx});
      wr_reg(3'h1, {2'b00, dir, cod, ood, m, 1'b1, ~tw | dir});
      i_peer.arm(pb, rel, m ? 1'b1 : ~tx);
      repeat (4) @(posedge mclk_i);
      #1;
      if (m) chk1(sclk_w, ~tx);
      chk1(sclk_oe_n, m ? (cod & ~tx) : 1'b1);
      if (tw && !dir) chk1(dout_oe_n, 1'b1);
      if (!ood && (dir || !tw)) chk1(dout_oe_n, 1'b0);
      chk1(free, tw);
      nedge = 8'h00;
      gmin = 8'hFF;
      gmax = 8'h00;
      txl = tx;
      chk_edge = !m || hf > 8'h01;
      // second write lands while busy and must be dropped
      @(posedge mclk_i);
      addr <= 3'h2;
      wdata <= db;
      wr <= 1'b1;
      @(posedge mclk_i);
      wdata <= ~db;
      @(posedge mclk_i);
      wr <= 1'b0;
      #1 chk1(busy, 1'b1);
      if (!m) i_peer.run_clock(800);
      for (int k = 0; k < 2000 && irq !== 1'b1; k++)
         @(negedge mclk_i);
      chk1(irq, 1'b1);
      chk1(busy, 1'b0);
      repeat (20) @(negedge mclk_i);
      chk_edge = 1'b0;
      chk8(nedge, 8'h10);
      if (m) chk8(gmin, hf);
      if (m) chk8(gmax, hf);
      if (!tw || dir) chk8(got, db);
      rd_reg(3'h2, r);
      if ((!m || hf > 8'h07) && !(tw && dir)) chk8(r, pb);
      rd_reg(3'h3, r);
      chk8(r, 8'h00);
      $display("test frame m%0b src%0d div8 %0b done", m, src, dv);
   endtask

   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      tick = 1'b0;
      tcnt = 2'h0;
      two = 1'b0;
      p_tx = 1'b0;
      chk_edge = 1'b0;
      txl = 1'b0;
      nedge = 8'h00;
      gap = 8'h00;
      gmin = 8'hFF;
      gmax = 8'h00;
      last_c = 1'b1;
      last_d = 1'b1;
      err_count = 0;
      tests_run = 0;
      cyc = 0;
      void'($urandom(38));
      repeat (4) @(posedge mclk_i);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk_i);
      for (int a = 0; a < 8; a++) begin
         rd_reg(3'(a), r);
         chk8(r, 8'h00);
      end
      $display("test reset values done");
      for (int i = 0; i < 16; i++)
         frame(1'b1, 2'(i), i[2], i[3], 1'($urandom), 1'b0, 1'b0);
      for (int i = 0; i < 4; i++)
         frame(1'b0, 2'h0, 1'b0, i[0], i[1], 1'b0, 1'b0);
      frame(1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      frame(1'b1, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
      // master without clock pin function must not start
      wr_reg(3'h0, 8'h20);
      wr_reg(3'h1, 8'h03);
      wr_reg(3'h2, 8'hA5);
      repeat (2) @(posedge mclk_i);
      #1 chk1(busy, 1'b0);
      $display("test master start refused done");
      // frozen clock enable must swallow a start that would otherwise run
      wr_reg(3'h1, 8'h07);
      ce <= 1'b0;
      wr_reg(3'h2, 8'h5A);
      @(posedge mclk_i);
      ce <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1 chk1(busy, 1'b0);
      $display("test clock enable freeze done");
      give_verdict();
   end
endmodule
`default_nettype wire

// ### verilog/pin_sync.sv
// two flip-flop synchroniser, one per bit
// assumes: inputs come from pins outside the mclk_i domain
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RESET_VAL = '1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         logic meta;
         // meta is read only by the second stage
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta <= RESET_VAL[i];
               q_o[i] <= RESET_VAL[i];
            end else if (ce_i) begin
               meta <= d_i[i];
               q_o[i] <= meta;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ### verilog/shift_clk_gen.sv
// half-period tick generator for the internal shift clock
// assumes: timer_tick_i is a one-cycle pulse on mclk_i
`timescale 1ns/1ns
`default_nettype none
`include "sync_serial_regs.svh"

module shift_clk_gen (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // control
   input wire logic run_i,
   input wire logic [1:0] src_i,
   input wire logic div8_i,
   input wire logic timer_tick_i,
   // tick out
   output logic half_tick_o
);

   logic [6:0] cnt;
   wire logic [6:0] base_half;
   wire logic [6:0] limit;
   wire logic step;

   assign base_half =
      (src_i == sync_serial_pkg::src_div2) ? `HALF_DIV2 :
      (src_i == sync_serial_pkg::src_div4) ? `HALF_DIV4 :
      (src_i == sync_serial_pkg::src_div16) ? `HALF_DIV16 : `HALF_TIMER;
   assign limit = div8_i ? {base_half[3:0], 3'b000} : base_half;
   assign step = (src_i == sync_serial_pkg::src_timer) ? timer_tick_i : 1'b1;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 7'h00;
         half_tick_o <= 1'b0;
      end else if (ce_i) begin
         if (!run_i) begin
            cnt <= 7'h00;
            half_tick_o <= 1'b0;
         end else if (step && cnt == limit - 7'h01) begin
            cnt <= 7'h00;
            half_tick_o <= 1'b1;
         end else begin
            cnt <= step ? cnt + 7'h01 : cnt;
            half_tick_o <= 1'b0;
         end
      end
   end

   a_div8_spacing: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || !ce_i || !run_i)
      (half_tick_o && div8_i && src_i == sync_serial_pkg::src_div2)
      |=> !half_tick_o [*7] ##1 half_tick_o)
      else $error("divide by 8 spacing wrong");

   a_div4_spacing: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || !ce_i || !run_i)
      (half_tick_o && !div8_i && src_i == sync_serial_pkg::src_div4)
      |=> !half_tick_o ##1 half_tick_o)
      else $error("divide by 4 spacing wrong");

endmodule

`default_nettype wire

// ### verilog/sync_serial_edge_clock_pins.sv
// clock-synchronous serial channel: edges, shift clock and pin set-up
// assumes: one system clock mclk_i; pins resolved outside from out/oe_n
`timescale 1ns/1ns
`default_nettype none
`include "sync_serial_regs.svh"

// Notes on behaviour
// - transmit data changes on falling edge when tx_edge_sel=0, else rising
// - receive sampled on opposite edge when rx_edge_relation=0, else same
// - internal clock makes us master driving clock; external makes slave
// - clock source picks fs/2, fs/4, fs/16 or timer 3 output
// - clk_div8_en set divides the selected internal clock by 8
// - input pin only receives; output pin may transmit or receive
// - input_pin_sel=1 takes data from output pin, frees input pin
// - in two-line mode shared_pin_dir sets shared pin direction
// - busy set on transfer start, cleared when done interrupt is raised
// - asynchronous-only flags are stored but have no effect
// - full duplex needs edge bits 00 or 01, sampling opposite edge
// - slave: clock pin input; master: output, push-pull or open-drain
// - master start needs clock pin enabled; slave does not
// - done interrupt after each frame, then shift data copied to buffer
module sync_serial_edge_clock_pins (
   // clock, reset, enable
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // register port
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // timer 3 output, one-cycle pulse
   input wire logic timer3_tick_i,
   // shift clock pin
   input wire logic shift_clk_pin_i,
   output logic shift_clk_pin_o,
   output logic shift_clk_pin_oe_n_o,
   // data output pin, shared in two-line mode
   input wire logic data_out_pin_i,
   output logic data_out_pin_o,
   output logic data_out_pin_oe_n_o,
   // data input pin
   input wire logic data_in_pin_i,
   output logic data_in_pin_free_o,
   // status
   output logic transfer_active_flag_o,
   output logic xfer_done_irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // reset release

   logic rst_meta;
   logic rst_n;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers and decode

   logic [7:0] serial_mode_a;
   logic [7:0] port_dir_reg;
   logic [7:0] async_flags;
   logic [7:0] shift_buffer;
   logic [7:0] rx_buf;
   logic [4:0] edge_cnt;
   logic sclk_int;
   logic tx_bit;
   logic ext_prev;
   sync_serial_pkg::xfer_state_t state;

   wire logic tx_edge_sel = serial_mode_a[`MODE_TX_EDGE];
   wire logic rx_edge_relation = serial_mode_a[`MODE_RX_REL];
   wire logic [1:0] clk_src_sel =
      serial_mode_a[`MODE_SRC_HI:`MODE_SRC_LO];
   wire logic clk_div8_en = serial_mode_a[`MODE_DIV8];
   wire logic master = serial_mode_a[`MODE_MASTER];
   wire logic input_pin_sel = serial_mode_a[`MODE_IN_SEL];
   wire logic out_pin_func_en = port_dir_reg[`PIN_OUT_EN];
   wire logic in_pin_func_en = port_dir_reg[`PIN_IN_EN];
   wire logic clk_pin_func_en = port_dir_reg[`PIN_CLK_EN];
   wire logic out_pin_drive_style = port_dir_reg[`PIN_OUT_OD];
   wire logic clk_pin_drive_style = port_dir_reg[`PIN_CLK_OD];
   wire logic shared_pin_dir = port_dir_reg[`PIN_DIR];

   wire logic idle_lvl = ~tx_edge_sel;
   wire logic running = (state == sync_serial_pkg::st_run);
   wire logic wr_mode = wr_i && addr_i == `ADDR_MODE;
   wire logic wr_pins = wr_i && addr_i == `ADDR_PINS;
   wire logic wr_data = wr_i && addr_i == `ADDR_DATA;
   wire logic wr_async = wr_i && addr_i == `ADDR_ASYNC;
   wire logic link_en = out_pin_func_en || in_pin_func_en;
   // data writes while busy are dropped so a running frame is never restarted
   wire logic start = wr_data && state == sync_serial_pkg::st_idle &&
      link_en && (!master || clk_pin_func_en);

   ////////////////////////////////////////////////////////////////////////
   // pin inputs and shift clock

   logic sclk_s;
   logic dout_s;
   logic din_s;
   logic half_tick;

   pin_sync #(.W(3), .RESET_VAL(3'h7)) u_pin_sync (
      .clk_i(mclk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .d_i({shift_clk_pin_i, data_out_pin_i, data_in_pin_i}),
      .q_o({sclk_s, dout_s, din_s})
   );

   shift_clk_gen u_clk_gen (
      .clk_i(mclk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .run_i(running && master),
      .src_i(clk_src_sel),
      .div8_i(clk_div8_en),
      .timer_tick_i(timer3_tick_i),
      .half_tick_o(half_tick)
   );

   wire logic rx_data = input_pin_sel ? dout_s : din_s;
   wire logic ext_edge = running && !master && (sclk_s != ext_prev);
   wire logic edge_ev = master ? (running && half_tick) : ext_edge;
   wire logic level_after = master ? ~sclk_int : sclk_s;
   wire logic tx_ev = edge_ev && (level_after == tx_edge_sel);
   // relation 0 is the only full-duplex safe choice
   wire logic rx_ev = edge_ev && (rx_edge_relation ?
      (level_after == tx_edge_sel) : (level_after != tx_edge_sel));
   wire logic last_edge = edge_ev && edge_cnt == `FRAME_EDGES - 5'h01;

   logic [7:0] next_shift;

   always_comb begin
      next_shift = shift_buffer;
      if (start) begin
         next_shift = wdata_i;
      end else if (tx_ev) begin
         next_shift = {shift_buffer[6:0], rx_ev ? rx_data : 1'b0};
      end else if (rx_ev) begin
         next_shift = {shift_buffer[7:1], rx_data};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transfer state

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= sync_serial_pkg::st_idle;
         edge_cnt <= 5'h00;
         shift_buffer <= `DATA_RESET;
         rx_buf <= `DATA_RESET;
         sclk_int <= 1'b1;
         tx_bit <= 1'b1;
         ext_prev <= 1'b1;
         transfer_active_flag_o <= 1'b0;
         xfer_done_irq_o <= 1'b0;
      end else if (ce_i) begin
         shift_buffer <= next_shift;
         ext_prev <= sclk_s;
         xfer_done_irq_o <= 1'b0;
         if (tx_ev) begin
            tx_bit <= shift_buffer[7];
         end
         case (state)
            sync_serial_pkg::st_idle: begin
               sclk_int <= idle_lvl;
               edge_cnt <= 5'h00;
               if (start) begin
                  state <= sync_serial_pkg::st_run;
                  transfer_active_flag_o <= 1'b1;
               end
            end
            sync_serial_pkg::st_run: begin
               if (master && half_tick) begin
                  sclk_int <= ~sclk_int;
               end
               if (edge_ev) begin
                  edge_cnt <= edge_cnt + 5'h01;
               end
               if (last_edge) begin
                  state <= sync_serial_pkg::st_copy;
                  transfer_active_flag_o <= 1'b0;
                  xfer_done_irq_o <= 1'b1;
               end
            end
            sync_serial_pkg::st_copy: begin
               rx_buf <= shift_buffer;
               state <= sync_serial_pkg::st_idle;
            end
            default: begin
               state <= sync_serial_pkg::st_idle;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers and read port

   logic [7:0] next_rdata;

   assign next_rdata =
      !rd_i ? 8'h00 :
      (addr_i == `ADDR_MODE) ? serial_mode_a :
      (addr_i == `ADDR_PINS) ? port_dir_reg :
      (addr_i == `ADDR_DATA) ? rx_buf :
      (addr_i == `ADDR_STATUS) ? {7'h00, transfer_active_flag_o} :
      (addr_i == `ADDR_ASYNC) ? async_flags : 8'h00;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         serial_mode_a <= `MODE_RESET;
         port_dir_reg <= `PINS_RESET;
         async_flags <= `ASYNC_RESET;
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         rdata_o <= next_rdata;
         if (wr_mode) begin
            serial_mode_a <= {1'b0, wdata_i[6:0]};
         end
         if (wr_pins) begin
            port_dir_reg <= {2'b00, wdata_i[5:0]};
         end
         if (wr_async) begin
            async_flags <= wdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers, low enable drives the pin

   wire logic clk_drive = master && clk_pin_func_en;
   // dir bit only matters once the output pin also receives
   wire logic out_drive = out_pin_func_en && (!input_pin_sel || shared_pin_dir);
   wire logic next_clk_oe_n =
      !(clk_drive && (!clk_pin_drive_style || !sclk_int));
   wire logic next_clk_o = clk_pin_drive_style ? 1'b0 : sclk_int;
   wire logic next_dout_oe_n =
      !(out_drive && (!out_pin_drive_style || !tx_bit));
   wire logic next_dout_o = out_pin_drive_style ? 1'b0 : tx_bit;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         shift_clk_pin_o <= 1'b1;
         shift_clk_pin_oe_n_o <= 1'b1;
         data_out_pin_o <= 1'b1;
         data_out_pin_oe_n_o <= 1'b1;
         data_in_pin_free_o <= 1'b0;
      end else if (ce_i) begin
         shift_clk_pin_o <= next_clk_o;
         shift_clk_pin_oe_n_o <= next_clk_oe_n;
         data_out_pin_o <= next_dout_o;
         data_out_pin_oe_n_o <= next_dout_oe_n;
         data_in_pin_free_o <= input_pin_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n || !ce_i);

   sequence s_start;
      start;
   endsequence

   sequence s_frame_end;
      transfer_active_flag_o && last_edge;
   endsequence

   a_busy_on_start: assert property (
      s_start |=> transfer_active_flag_o && running)
      else $error("busy not set on start");

   a_busy_clear_irq: assert property (
      s_frame_end |=> xfer_done_irq_o && !transfer_active_flag_o)
      else $error("busy not cleared with interrupt");

   a_buffer_copy: assert property (
      xfer_done_irq_o |=> rx_buf == $past(shift_buffer))
      else $error("receive buffer not copied after interrupt");

   a_clock_idle: assert property (
      (state == sync_serial_pkg::st_idle) ##1
      (state == sync_serial_pkg::st_idle) |-> sclk_int == $past(idle_lvl))
      else $error("master clock not idle");

   a_tx_edge_only: assert property (
      $changed(tx_bit) |-> $past(tx_ev) && $past(level_after) == $past(tx_edge_sel))
      else $error("transmit data moved off its edge");

   a_rx_edge_rel: assert property (
      rx_ev && !rx_edge_relation |-> !tx_ev)
      else $error("receive sampled on transmit edge");

   a_slave_clk_in: assert property (
      !master ##1 !master |-> shift_clk_pin_oe_n_o)
      else $error("slave drives the clock pin");

   a_two_line_in: assert property (
      (input_pin_sel && !shared_pin_dir) ##1
      (input_pin_sel && !shared_pin_dir) |-> data_out_pin_oe_n_o)
      else $error("shared pin driven while receiving");

   a_in_pin_free: assert property (
      input_pin_sel |=> data_in_pin_free_o)
      else $error("input pin not released");

   a_master_gate: assert property (
      wr_data && master && !clk_pin_func_en |=> !transfer_active_flag_o
      || $past(transfer_active_flag_o))
      else $error("master started without clock pin");

endmodule

`default_nettype wire

// ### verilog/sync_serial_pkg.sv
// types shared by the serial channel design files
// assumes: compiled before every module that names it
package sync_serial_pkg;

   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_run = 3'b010,
      st_copy = 3'b100
   } xfer_state_t;

   typedef enum logic [1:0] {
      src_div2 = 2'h0,
      src_div4 = 2'h1,
      src_div16 = 2'h2,
      src_timer = 2'h3
   } clk_src_t;

endpackage

// ### verilog/sync_serial_regs.svh
// register offsets, field positions and reset values of the serial channel
// assumes: included by bare name from the design files
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

// register offsets (3-bit address)
`define ADDR_MODE 3'h0
`define ADDR_PINS 3'h1
`define ADDR_DATA 3'h2
`define ADDR_STATUS 3'h3
`define ADDR_ASYNC 3'h4

// mode register fields
`define MODE_TX_EDGE 0
`define MODE_RX_REL 1
`define MODE_SRC_LO 2
`define MODE_SRC_HI 3
`define MODE_DIV8 4
`define MODE_MASTER 5
`define MODE_IN_SEL 6

// pin register fields
`define PIN_OUT_EN 0
`define PIN_IN_EN 1
`define PIN_CLK_EN 2
`define PIN_OUT_OD 3
`define PIN_CLK_OD 4
`define PIN_DIR 5

// reset values
`define MODE_RESET 8'h00
`define PINS_RESET 8'h00
`define ASYNC_RESET 8'h00
`define DATA_RESET 8'h00

// timing counts per half shift-clock period, in system clocks (timer 3 pulses for HALF_TIMER)
`define HALF_DIV2 7'h01
`define HALF_DIV4 7'h02
`define HALF_DIV16 7'h08
`define HALF_TIMER 7'h01

// shift-clock edges in one 8-bit frame
`define FRAME_EDGES 5'h10

`endif
